//--- shared/gpc_pkg.sv
// shared constants for the gpio port pin control block
package gpc_pkg;
  localparam int NUM_PINS = 26;
  localparam int CAP_SEL_W = 5;
  localparam int APB_AW = 12;
  localparam logic [7:0] OFF_DATA = 8'h00;
  localparam logic [7:0] OFF_DIR = 8'h04;
  localparam logic [7:0] OFF_PULL = 8'h08;
  localparam logic [7:0] OFF_DRV = 8'h0C;
  localparam logic [7:0] OFF_SENSE = 8'h10;
  localparam logic [7:0] OFF_BOTH = 8'h14;
  localparam logic [7:0] OFF_POL = 8'h18;
  localparam logic [7:0] OFF_MASK = 8'h1C;
  localparam logic [7:0] OFF_RAW = 8'h20;
  localparam logic [7:0] OFF_MSKD = 8'h24;
  localparam logic [7:0] OFF_ICLR = 8'h28;
  localparam logic [7:0] OFF_FUNC0 = 8'h2C;
  localparam logic [7:0] OFF_FUNC1 = 8'h30;
  localparam logic [7:0] OFF_FUNC2 = 8'h34;
  localparam logic [7:0] OFF_FUNC3 = 8'h38;
  localparam logic [7:0] OFF_DSET = 8'h3C;
  localparam logic [7:0] OFF_DCLR = 8'h40;
  localparam logic [7:0] OFF_CAP = 8'h44;
  localparam logic [31:0] RST_DATA = 32'h00000000;
  localparam logic [31:0] RST_DIR = 32'h00000000;
  localparam logic [31:0] RST_PULL = 32'h003FFFFF;
  localparam logic [31:0] RST_DRV = 32'h00000000;
  localparam logic [31:0] RST_IRQCFG = 32'h00000000;
  localparam logic [31:0] RST_CAP = 32'h00000000;
  localparam logic [3:0][31:0] RST_FUNC = {32'h00000000, 32'h00000000,
                                           32'h00000110, 32'h00000000};
  localparam int FN_W = 3;
  localparam int FN_STRIDE = 4;
  localparam int FN_PER_WORD = 8;
  localparam logic [2:0] FN_GPIO = 3'h0;
  localparam logic [2:0] FN_ALT_B = 3'h1;
  localparam logic [2:0] FN_ALT_A = 3'h4;
  localparam logic [2:0] FN_ALT_C = 3'h5;
endpackage

//--- rtl/gpc_top.sv
// gpio port: pin data, direction, pull, drive, function select, pin interrupts
// What this block does
// - interrupt clear writes one to drop raw bit
// - function codes gpio, alt b, alt a, alt c
// - function selectors in four words 0x2C-0x38
// - function word one resets to 0x110
// - data set write forces ones
// - data clear write forces zeros
// - data drives pin only in gpio output
// - data read returns sampled pin level
// - direction bit one means output, resets zero
// - pull enable bits, pins 0-21 on at reset
// - drive strength bits, reset low drive
// - sense bit selects edge or level
// - capture select routes one pin to timers
// - matching pin condition sets raw status
// - both-edges and polarity shape the condition
// - masked status is raw and mask
// - masked conditions merge into one request
`timescale 1ns/100ps
module gpc_top
  import gpc_pkg::*;
#(
  parameter int NPINS = NUM_PINS
) (
  input wire logic core_clk_i, // 40 MHz system clock
  input wire logic rst_n_i, // async reset, active low
  input wire logic psel_i, // apb select
  input wire logic penable_i, // apb access phase
  input wire logic pwrite_i, // apb direction, 1 write
  input wire logic [APB_AW-1:0] paddr_i, // apb byte address
  input wire logic [31:0] pwdata_i, // apb write data
  output logic [31:0] prdata_o, // apb read data
  output logic pready_o, // apb ready
  output logic pslverr_o, // apb error on unmapped address
  input wire logic [NPINS-1:0] pad_in_i, // pin levels, asynchronous
  output logic [NPINS-1:0] pad_out_o, // pin output level
  output logic [NPINS-1:0] pad_oe_o, // pin output enable, 1 drives
  output logic [NPINS-1:0] pad_pull_en_o, // pin pull resistor enable
  output logic [NPINS-1:0] pad_drive_o, // pin drive, 1 high drive
  input wire logic [NPINS-1:0] alt_a_out_i, // alt function a output
  input wire logic [NPINS-1:0] alt_a_oe_i, // alt function a enable
  input wire logic [NPINS-1:0] alt_b_out_i, // alt function b output
  input wire logic [NPINS-1:0] alt_b_oe_i, // alt function b enable
  input wire logic [NPINS-1:0] alt_c_out_i, // alt function c output
  input wire logic [NPINS-1:0] alt_c_oe_i, // alt function c enable
  output logic [NPINS-1:0] pin_level_o, // synchronised pin levels
  output logic cap_in_o, // selected pin to timer capture
  output logic irq_o // level interrupt request
);

  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!rst_n_i);

  function automatic logic [31:0] zext(input logic [NPINS-1:0] v);
    zext = {{(32-NPINS){1'b0}}, v};
  endfunction

  // apb: setup edge captures read data, access phase always one cycle
  logic pready_ff;
  logic pslverr_ff;
  logic [31:0] prdata_ff;
  logic [31:0] rdata;
  logic unmapped;
  wire setup_w = psel_i && !penable_i;
  wire commit_w = psel_i && penable_i && pready_ff;
  wire wr_w = commit_w && pwrite_i && !pslverr_ff;
  wire [7:0] off_w = paddr_i[7:0];
  wire hi_zero_w = (paddr_i[APB_AW-1:8] == '0) && (paddr_i[1:0] == 2'h0);
  wire [NPINS-1:0] wbits = pwdata_i[NPINS-1:0];

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pready_ff <= 1'b0;
      pslverr_ff <= 1'b0;
      prdata_ff <= 32'h00000000;
    end else begin
      pready_ff <= setup_w;
      pslverr_ff <= setup_w && unmapped;
      if (setup_w) begin
        prdata_ff <= (pwrite_i || unmapped) ? 32'h00000000 : rdata;
      end
    end
  end

  // pin synchroniser, first stage read only by second
  logic [NPINS-1:0] pin_meta_ff;
  logic [NPINS-1:0] pin_s_ff;
  logic [NPINS-1:0] pin_prev_ff;
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pin_meta_ff <= '0;
      pin_s_ff <= '0;
      pin_prev_ff <= '0;
    end else begin
      pin_meta_ff <= pad_in_i;
      pin_s_ff <= pin_meta_ff;
      pin_prev_ff <= pin_s_ff;
    end
  end

  // configuration registers
  logic [NPINS-1:0] data_ff;
  logic [NPINS-1:0] dir_ff;
  logic [NPINS-1:0] pull_ff;
  logic [NPINS-1:0] drv_ff;
  logic [NPINS-1:0] sense_ff;
  logic [NPINS-1:0] both_ff;
  logic [NPINS-1:0] pol_ff;
  logic [NPINS-1:0] mask_ff;
  logic [NPINS-1:0] raw_ff;
  logic [CAP_SEL_W-1:0] cap_sel_ff;
  logic [NPINS-1:0] nxt_data;
  logic [NPINS-1:0] nxt_raw;

  wire wr_data = wr_w && (off_w == OFF_DATA);
  wire wr_set = wr_w && (off_w == OFF_DSET);
  wire wr_clr = wr_w && (off_w == OFF_DCLR);
  wire wr_iclr = wr_w && (off_w == OFF_ICLR);

  assign nxt_data = wr_data ? wbits :
                    wr_set ? (data_ff | wbits) :
                    wr_clr ? (data_ff & ~wbits) :
                    data_ff;

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      data_ff <= RST_DATA[NPINS-1:0];
      dir_ff <= RST_DIR[NPINS-1:0];
      pull_ff <= RST_PULL[NPINS-1:0];
      drv_ff <= RST_DRV[NPINS-1:0];
      sense_ff <= RST_IRQCFG[NPINS-1:0];
      both_ff <= RST_IRQCFG[NPINS-1:0];
      pol_ff <= RST_IRQCFG[NPINS-1:0];
      mask_ff <= RST_IRQCFG[NPINS-1:0];
      cap_sel_ff <= RST_CAP[CAP_SEL_W-1:0];
    end else begin
      data_ff <= nxt_data;
      if (wr_w && off_w == OFF_DIR) dir_ff <= wbits;
      if (wr_w && off_w == OFF_PULL) pull_ff <= wbits;
      if (wr_w && off_w == OFF_DRV) drv_ff <= wbits;
      if (wr_w && off_w == OFF_SENSE) sense_ff <= wbits;
      if (wr_w && off_w == OFF_BOTH) both_ff <= wbits;
      if (wr_w && off_w == OFF_POL) pol_ff <= wbits;
      if (wr_w && off_w == OFF_MASK) mask_ff <= wbits;
      if (wr_w && off_w == OFF_CAP) cap_sel_ff <= pwdata_i[CAP_SEL_W-1:0];
    end
  end

  // interrupt detection
  wire [NPINS-1:0] rise_w = pin_s_ff & ~pin_prev_ff;
  wire [NPINS-1:0] fall_w = ~pin_s_ff & pin_prev_ff;
  wire [NPINS-1:0] lvl_hit = ~(pin_s_ff ^ pol_ff);
  wire [NPINS-1:0] edge_hit = (both_ff & (rise_w | fall_w)) |
                              (~both_ff & ((pol_ff & rise_w) | (~pol_ff & fall_w)));
  wire [NPINS-1:0] evt_w = (sense_ff & lvl_hit) | (~sense_ff & edge_hit);
  wire [NPINS-1:0] mskd_w = raw_ff & mask_ff;

  // a new event wins over a clear in the same cycle
  assign nxt_raw = (raw_ff & ~(wr_iclr ? wbits : '0)) | evt_w;

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      raw_ff <= '0;
    end else begin
      raw_ff <= nxt_raw;
    end
  end

  // function selectors, one field per pin
  logic [FN_W-1:0] func_ff [NPINS];
  logic [NPINS-1:0] nxt_out;
  logic [NPINS-1:0] nxt_oe;
  logic [NPINS-1:0] gpio_sel;
  logic [NPINS-1:0] alt_b_sel;
  logic [NPINS-1:0] rsvd_sel;
  logic [3:0][31:0] func_word;

  for (genvar i = 0; i < NPINS; i++) begin : g_pin
    localparam int GRP = i / FN_PER_WORD;
    localparam int LSB = (i % FN_PER_WORD) * FN_STRIDE;
    localparam logic [FN_W-1:0] FRST = RST_FUNC[GRP][LSB +: FN_W];
    localparam logic [7:0] FOFF = OFF_FUNC0 + 8'(GRP * 4);
    wire wr_fn = wr_w && (off_w == FOFF);
    wire [FN_W-1:0] fn = func_ff[i];
    wire fg = (fn == FN_GPIO);
    wire fa = (fn == FN_ALT_A);
    wire fb = (fn == FN_ALT_B);
    wire fc = (fn == FN_ALT_C);
    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
        func_ff[i] <= FRST;
      end else if (wr_fn) begin
        func_ff[i] <= pwdata_i[LSB +: FN_W];
      end
    end
    assign gpio_sel[i] = fg;
    assign alt_b_sel[i] = fb;
    assign rsvd_sel[i] = !(fg || fa || fb || fc);
    // reserved codes select no source, so the pin floats
    assign nxt_out[i] = fg ? data_ff[i] :
                        fa ? alt_a_out_i[i] :
                        fb ? alt_b_out_i[i] :
                        fc ? alt_c_out_i[i] : 1'b0;
    assign nxt_oe[i] = fg ? dir_ff[i] :
                       fa ? alt_a_oe_i[i] :
                       fb ? alt_b_oe_i[i] :
                       fc ? alt_c_oe_i[i] : 1'b0;
  end

  // read view of the function words, reserved bits zero
  always_comb begin
    func_word = '0;
    for (int i = 0; i < NPINS; i++) begin
      func_word[i / FN_PER_WORD][(i % FN_PER_WORD) * FN_STRIDE +: FN_W] = func_ff[i];
    end
  end

  // read mux and address decode
  always_comb begin
    rdata = 32'h00000000;
    unmapped = !hi_zero_w;
    unique case (off_w)
      OFF_DATA: rdata = zext(pin_s_ff);
      OFF_DIR: rdata = zext(dir_ff);
      OFF_PULL: rdata = zext(pull_ff);
      OFF_DRV: rdata = zext(drv_ff);
      OFF_SENSE: rdata = zext(sense_ff);
      OFF_BOTH: rdata = zext(both_ff);
      OFF_POL: rdata = zext(pol_ff);
      OFF_MASK: rdata = zext(mask_ff);
      OFF_RAW: rdata = zext(raw_ff);
      OFF_MSKD: rdata = zext(mskd_w);
      OFF_ICLR: rdata = 32'h00000000;
      OFF_FUNC0: rdata = func_word[0];
      OFF_FUNC1: rdata = func_word[1];
      OFF_FUNC2: rdata = func_word[2];
      OFF_FUNC3: rdata = func_word[3];
      OFF_DSET: rdata = 32'h00000000;
      OFF_DCLR: rdata = 32'h00000000;
      OFF_CAP: rdata = {{(32-CAP_SEL_W){1'b0}}, cap_sel_ff};
      default: unmapped = 1'b1;
    endcase
  end

  // capture routing; out-of-range selections give zero
  wire cap_ok = cap_sel_ff < CAP_SEL_W'(NPINS);
  wire cap_w = cap_ok ? pin_s_ff[cap_sel_ff] : 1'b0;

  // output flops
  logic [NPINS-1:0] out_ff;
  logic [NPINS-1:0] oe_ff;
  logic [NPINS-1:0] pull_o_ff;
  logic [NPINS-1:0] drv_o_ff;
  logic [NPINS-1:0] lvl_o_ff;
  logic cap_ff;
  logic irq_ff;
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      out_ff <= '0;
      oe_ff <= '0;
      pull_o_ff <= RST_PULL[NPINS-1:0];
      drv_o_ff <= RST_DRV[NPINS-1:0];
      lvl_o_ff <= '0;
      cap_ff <= 1'b0;
      irq_ff <= 1'b0;
    end else begin
      out_ff <= nxt_out;
      oe_ff <= nxt_oe;
      pull_o_ff <= pull_ff;
      drv_o_ff <= drv_ff;
      lvl_o_ff <= pin_s_ff;
      cap_ff <= cap_w;
      irq_ff <= |mskd_w;
    end
  end

  assign prdata_o = prdata_ff;
  assign pready_o = pready_ff;
  assign pslverr_o = pslverr_ff;
  assign pad_out_o = out_ff;
  assign pad_oe_o = oe_ff;
  assign pad_pull_en_o = pull_o_ff;
  assign pad_drive_o = drv_o_ff;
  assign pin_level_o = lvl_o_ff;
  assign cap_in_o = cap_ff;
  assign irq_o = irq_ff;

  // checks
  a_set_forces_ones: assert property (wr_set |=>
    ((data_ff & $past(wbits)) == $past(wbits)) &&
    ((data_ff & ~$past(wbits)) == ($past(data_ff) & ~$past(wbits))))
    else $error("data set write did not force ones");

  a_clr_forces_zero: assert property (wr_clr |=>
    ((data_ff & $past(wbits)) == '0) &&
    ((data_ff & ~$past(wbits)) == ($past(data_ff) & ~$past(wbits))))
    else $error("data clear write did not force zeros");

  a_iclr_drops_raw: assert property (wr_iclr |=>
    ((raw_ff & $past(wbits) & ~$past(evt_w)) == '0))
    else $error("interrupt clear left raw bit set");

  a_event_sets_raw: assert property (1'b1 |=>
    ((raw_ff & $past(evt_w)) == $past(evt_w)))
    else $error("pin event did not set raw status");

  a_level_match: assert property (1'b1 |=>
    ((raw_ff & $past(sense_ff & ~(pin_s_ff ^ pol_ff))) ==
     $past(sense_ff & ~(pin_s_ff ^ pol_ff))))
    else $error("level condition missed");

  a_gpio_drives_pin: assert property (1'b1 |=>
    (((pad_out_o ^ $past(data_ff)) & $past(gpio_sel & dir_ff)) == '0) &&
    ((pad_oe_o & $past(gpio_sel)) == $past(gpio_sel & dir_ff)))
    else $error("gpio pin drive mismatch");

  a_data_read_pin: assert property (setup_w && !pwrite_i && off_w == OFF_DATA &&
    hi_zero_w |=> pready_o && prdata_o == zext($past(pin_s_ff)))
    else $error("data read is not pin level");

  a_irq_from_mask: assert property (1'b1 |=>
    (irq_o == $past(|(raw_ff & mask_ff))))
    else $error("interrupt output not masked status");

  a_pull_to_pad: assert property (1'b1 |=> pad_pull_en_o == $past(pull_ff))
    else $error("pull enable output not register copy");

  a_drive_to_pad: assert property (1'b1 |=> pad_drive_o == $past(drv_ff))
    else $error("drive output not register copy");

  a_reserved_no_drive: assert property (1'b1 |=>
    ((pad_oe_o & $past(rsvd_sel)) == '0) &&
    ((pad_out_o & $past(rsvd_sel)) == '0))
    else $error("reserved function code drives pin");

  a_alt_b_oe: assert property (1'b1 |=>
    (((pad_oe_o ^ $past(alt_b_oe_i)) & $past(alt_b_sel)) == '0))
    else $error("alt b enable not routed");

  a_strobe_reads_zero: assert property (setup_w && !pwrite_i &&
    (off_w == OFF_DSET || off_w == OFF_DCLR) |=> prdata_o == 32'h00000000)
    else $error("set or clear word read not zero");

  a_masked_read_and: assert property (setup_w && !pwrite_i && off_w == OFF_MSKD &&
    hi_zero_w |=> prdata_o == zext($past(raw_ff & mask_ff)))
    else $error("masked status read not raw and mask");

  a_edge_needs_change: assert property (1'b1 |=>
    ((raw_ff & ~$past(raw_ff) & $past(~sense_ff)) &
     ~$past(pin_s_ff ^ pin_prev_ff)) == '0)
    else $error("edge mode raw set without pin change");

  a_single_edge_pol: assert property (1'b1 |=>
    (raw_ff & ~$past(raw_ff) &
     $past(~sense_ff & ~both_ff & (pin_s_ff ^ pol_ff))) == '0)
    else $error("single edge of wrong polarity set raw");

  a_dir_write_lands: assert property (wr_w && off_w == OFF_DIR |=>
    dir_ff == $past(wbits))
    else $error("direction write lost");

  a_unmapped_slave_err: assert property (setup_w && unmapped |=>
    pready_o && pslverr_o && prdata_o == 32'h00000000)
    else $error("unmapped access not refused");

  a_iclr_zero_keeps: assert property (wr_iclr |=>
    ((raw_ff & ~$past(wbits)) ==
     (($past(raw_ff) | $past(evt_w)) & ~$past(wbits))))
    else $error("interrupt clear zero bit changed raw");

  a_apb_one_cycle: assert property (setup_w |=> pready_o ##1 !pready_o)
    else $error("apb access phase not one cycle");

  a_cap_routes_pin: assert property (cap_ok |=>
    (cap_in_o == $past(pin_s_ff[cap_sel_ff])))
    else $error("capture input not selected pin");

endmodule

//--- sim/tb_gpc_top.sv
// self-checking bench for the gpio port pin control block
`timescale 1ns/100ps
`define CHK(nm, exp, got) begin comparisons++; if ((got) !== (exp)) begin miscompares++; \
  $display("[FAIL] %s exp %h got %h", nm, exp, got); end end
module tb_gpc_top;
  import gpc_pkg::*;
  logic core_clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic psel_i = 1'b0;
  logic penable_i = 1'b0;
  logic pwrite_i = 1'b0;
  logic [APB_AW-1:0] paddr_i = '0;
  logic [31:0] pwdata_i = '0;
  logic [NUM_PINS-1:0] pad_in_i = '0;
  // distinct patterns per source so a wrong mux leg shows up
  logic [NUM_PINS-1:0] a_out = 26'h00000A5;
  logic [NUM_PINS-1:0] a_oe = 26'h00000F0;
  logic [NUM_PINS-1:0] b_out = 26'h000003C;
  logic [NUM_PINS-1:0] b_oe = 26'h2A5540F;
  logic [NUM_PINS-1:0] c_out = 26'h00000C3;
  logic [NUM_PINS-1:0] c_oe = 26'h00000CC;
  logic [31:0] prdata_o;
  logic pready_o, pslverr_o, cap_in_o, irq_o;
  logic [NUM_PINS-1:0] pad_out_o, pad_oe_o, pad_pull_en_o, pad_drive_o, pin_level_o;
  int miscompares = 0;
  int comparisons = 0;
  logic [31:0] rd;
  logic er;

  always #12.5 core_clk_i = ~core_clk_i;

  gpc_top #(.NPINS(NUM_PINS)) gpc_top_i (
    .core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .psel_i(psel_i), .penable_i(penable_i),
    .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o),
    .pready_o(pready_o), .pslverr_o(pslverr_o), .pad_in_i(pad_in_i), .pad_out_o(pad_out_o),
    .pad_oe_o(pad_oe_o), .pad_pull_en_o(pad_pull_en_o), .pad_drive_o(pad_drive_o),
    .alt_a_out_i(a_out), .alt_a_oe_i(a_oe), .alt_b_out_i(b_out), .alt_b_oe_i(b_oe),
    .alt_c_out_i(c_out), .alt_c_oe_i(c_oe), .pin_level_o(pin_level_o),
    .cap_in_o(cap_in_o), .irq_o(irq_o));

  task automatic print_verdict();
    if (miscompares == 0 && comparisons > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n = 0;
    @(posedge core_clk_i);
    psel_i <= 1'b1;
    penable_i <= 1'b0;
    pwrite_i <= wr;
    paddr_i <= {4'h0, a};
    pwdata_i <= d;
    @(posedge core_clk_i);
    penable_i <= 1'b1;
    do begin
      @(posedge core_clk_i);
      n++;
    end while (pready_o !== 1'b1 && n < 50);
    if (n >= 50) begin
      miscompares++;
      $display("[FAIL] pready exp 1 got %b", pready_o);
    end
    rd = prdata_o;
    er = pslverr_o;
    psel_i <= 1'b0;
    penable_i <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task automatic chk_rd(input logic [7:0] a, input logic [31:0] e, input string nm);
    apb(1'b0, a, 32'h0);
    `CHK(nm, e, rd);
  endtask

  // outputs are looked at 1 ns after the edge, once register updates landed
  task automatic tick(input int n);
    repeat (n) @(posedge core_clk_i);
    #1;
  endtask

  task automatic t_reset();
    chk_rd(OFF_DATA, 32'h00000000, "data");
    chk_rd(OFF_DIR, 32'h00000000, "dir");
    chk_rd(OFF_PULL, 32'h003FFFFF, "pull");
    chk_rd(OFF_DRV, 32'h00000000, "drive");
    chk_rd(OFF_SENSE, 32'h00000000, "sense");
    chk_rd(OFF_FUNC0, 32'h00000000, "func0");
    chk_rd(OFF_FUNC1, 32'h00000110, "func1");
    chk_rd(OFF_FUNC2, 32'h00000000, "func2");
    chk_rd(OFF_FUNC3, 32'h00000000, "func3");
    chk_rd(OFF_CAP, 32'h00000000, "cap");
    `CHK("oe_rst", 26'h0000400, pad_oe_o);
    `CHK("pull_rst", 26'h03FFFFF, pad_pull_en_o);
    wr(OFF_PULL, 32'h0);
    wr(OFF_DRV, 32'h03FFFFFF);
    tick(2);
    `CHK("pull_off", 26'h0000000, pad_pull_en_o);
    `CHK("drive_hi", 26'h3FFFFFF, pad_drive_o);
  endtask

  task automatic t_data();
    wr(OFF_FUNC1, 32'h0);
    wr(OFF_DIR, 32'h03FFFFFF);
    wr(OFF_DATA, 32'h0);
    wr(OFF_DSET, 32'h02000301);
    tick(2);
    `CHK("set", 26'h2000301, pad_out_o);
    wr(OFF_DSET, 32'h00000010);
    wr(OFF_DCLR, 32'h00000300);
    tick(2);
    `CHK("clr", 26'h2000011, pad_out_o);
    chk_rd(OFF_DSET, 32'h0, "set_rd");
    chk_rd(OFF_DCLR, 32'h0, "clr_rd");
    wr(OFF_DIR, 32'h00000001);
    tick(2);
    `CHK("oe_dir", 26'h0000001, pad_oe_o);
  endtask

  task automatic t_func();
    logic [2:0] cd [5] = '{3'h0, 3'h1, 3'h4, 3'h5, 3'h2};
    logic [7:0] eo [5] = '{8'h5A, 8'h3C, 8'hA5, 8'hC3, 8'h00};
    logic [7:0] ee [5] = '{8'h33, 8'h0F, 8'hF0, 8'hCC, 8'h00};
    logic [2:0] g;
    wr(OFF_DIR, 32'h00000033);
    wr(OFF_DATA, 32'h0000005A);
    for (int i = 0; i < 5; i++) begin
      wr(OFF_FUNC0, {8{1'b0, cd[i]}});
      tick(2);
      `CHK("fn_oe", ee[i], pad_oe_o[7:0]);
      `CHK("fn_out", eo[i] & ee[i], pad_out_o[7:0] & pad_oe_o[7:0]);
    end
    wr(OFF_FUNC0, 32'h0);
    wr(OFF_FUNC3, 32'hFFFFFFFF);
    chk_rd(OFF_FUNC3, 32'h00000077, "func3_rd");
    wr(OFF_FUNC3, 32'h00000010);
    wr(OFF_FUNC2, 32'h00000001);
    tick(2);
    g = {pad_oe_o[25], pad_oe_o[24], pad_oe_o[16]};
    `CHK("grp_oe", 3'b101, g);
  endtask

  task automatic t_irq();
    wr(OFF_POL, 32'h00000008);
    wr(OFF_ICLR, 32'h03FFFFFF);
    wr(OFF_MASK, 32'h00000008);
    tick(2);
    `CHK("irq_idle", 1'b0, irq_o);
    @(posedge core_clk_i);
    pad_in_i <= 26'h0000008;
    tick(6);
    chk_rd(OFF_RAW, 32'h00000008, "raw_rise");
    `CHK("irq_set", 1'b1, irq_o);
    wr(OFF_ICLR, 32'h0);
    chk_rd(OFF_MSKD, 32'h00000008, "clr_zero");
    wr(OFF_ICLR, 32'h00000008);
    chk_rd(OFF_RAW, 32'h0, "raw_clr");
    `CHK("irq_clr", 1'b0, irq_o);
    wr(OFF_BOTH, 32'h00000008);
    @(posedge core_clk_i);
    pad_in_i <= 26'h0000000;
    tick(6);
    chk_rd(OFF_RAW, 32'h00000008, "raw_fall");
    wr(OFF_SENSE, 32'h00000010);
    tick(3);
    chk_rd(OFF_RAW, 32'h00000018, "raw_lvl");
    chk_rd(OFF_MSKD, 32'h00000008, "mskd_and");
    wr(OFF_ICLR, 32'h00000010);
    chk_rd(OFF_RAW, 32'h00000018, "lvl_hold");
  endtask

  task automatic t_pin();
    @(posedge core_clk_i);
    pad_in_i <= 26'h2000020;
    tick(4);
    `CHK("lvl", 26'h2000020, pin_level_o);
    chk_rd(OFF_DATA, 32'h02000020, "data_pin");
    wr(OFF_CAP, 32'h00000005);
    tick(3);
    `CHK("cap5", 1'b1, cap_in_o);
    wr(OFF_CAP, 32'h00000019);
    tick(3);
    `CHK("cap25", 1'b1, cap_in_o);
    wr(OFF_CAP, 32'h00000004);
    tick(3);
    `CHK("cap4", 1'b0, cap_in_o);
    chk_rd(OFF_CAP, 32'h00000004, "cap_rd");
    apb(1'b0, 8'h48, 32'h0);
    `CHK("unmap_err", 1'b1, er);
    `CHK("unmap_rd", 32'h0, rd);
    apb(1'b0, 8'h02, 32'h0);
    `CHK("misalign_err", 1'b1, er);
  endtask

  initial begin
    #(25 * 20000);
    miscompares++;
    $display("[FAIL] watchdog exp finish got timeout");
    print_verdict();
  end

  initial begin
    repeat (5) @(posedge core_clk_i);
    rst_n_i <= 1'b1;
    t_reset();
    t_data();
    t_func();
    t_irq();
    t_pin();
    print_verdict();
  end
endmodule
